// ### hw/wlsr_pkg.sv
// Constants shared by the wake-latch and output routing register block.
// Assumes a 16-bit register word with an 8-bit address from the serial configuration port.
package wlsr_pkg;

	// ==========================================================================
	// Register addresses
	localparam logic [7:0] ADDR_CHANGE_LATCH = 8'h33;
	localparam logic [7:0] ADDR_ROUTE_1_2    = 8'h34;
	localparam logic [7:0] ADDR_ROUTE_3_4    = 8'h35;

	// ==========================================================================
	// Sizes
	localparam int NUM_CHANNELS = 15;
	localparam int NUM_OUTPUTS  = 4;
	localparam int ROUTE_W      = 4;
	localparam int DATA_W       = 16;
	localparam int ADDR_W       = 8;

	// ==========================================================================
	// Field positions inside a routing register
	localparam int POS_ROUTE_LO  = 0;
	localparam int POS_ROUTE_HI  = 4;
	localparam int POS_PULLUP_LO = 8;
	localparam int POS_PULLUP_HI = 9;
	localparam int POS_BYPASS_LO = 10;
	localparam int POS_BYPASS_HI = 11;
	localparam int POS_FILTER_LO = 12;
	localparam int POS_FILTER_HI = 13;

	// ==========================================================================
	// Field codes and reset values
	localparam logic [3:0]  ROUTE_NONE      = 4'h0;
	localparam logic [3:0]  ROUTE_RST_OUT4  = 4'hf;
	localparam logic [3:0]  ROUTE_RST_OTHER = 4'h0;
	localparam logic        BYPASS_RST      = 1'h0;
	localparam logic        PULLUP_RST      = 1'h0;
	localparam logic [14:0] LATCH_RST       = 15'h0000;
	localparam logic [15:0] RDATA_RST       = 16'h0000;
	localparam logic [1:0]  SYNC_RST        = 2'h3;

	// One output's configuration.
	typedef struct packed {
		logic       filter_fast;
		logic       bypass;
		logic       pull_en;
		logic [3:0] route;
	} wlsr_out_cfg_s;

endpackage : wlsr_pkg

// ### hw/wlsr_slot_if.sv
// Carrier between the register block and one routing slot.
// Assumes all members live on clk_sys.
`timescale 1ns/1ps

interface wlsr_slot_if;
	logic [3:0]  route;
	logic [14:0] levels;
	logic        level;
	logic        drive;

	modport cfg  (output route, output levels, input level, input drive);
	modport slot (input route, input levels, output level, output drive);
endinterface : wlsr_slot_if

// ### hw/wlsr_route_slot.sv
// One routed output: picks an input channel by its selector code.
// Assumes channel levels are already on clk_sys.
`timescale 1ns/1ps

module wlsr_route_slot (
	// Clock and reset
	input wire logic     clk_sys,
	input wire logic     reset_n,
	// Configuration and data
	wlsr_slot_if.slot    port
);

	typedef struct packed {
		logic level;
		logic drive;
	} wlsr_slot_s;

	wlsr_slot_s st_ff;
	wlsr_slot_s nxt_st;

	// ==========================================================================
	// Selection
	always_comb begin
		nxt_st = st_ff;
		if (port.route == wlsr_pkg::ROUTE_NONE) begin
			nxt_st.drive = 1'b0; // RULE8
			nxt_st.level = 1'b0;
		end else begin
			nxt_st.drive = 1'b1;
			nxt_st.level = port.levels[port.route - 4'h1]; // RULE8
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign port.level = st_ff.level;
	assign port.drive = st_ff.drive;

endmodule : wlsr_route_slot

// ### hw/wlsr_change_latch.sv
// Level change latch captured at the end of the polling phase.
// Assumes levels and the end strobe come from logic on clk_sys.
`timescale 1ns/1ps

module wlsr_change_latch (
	// Clock and power-on reset
	input wire logic         clk_sys,
	input wire logic         reset_n,
	// Polling results
	input wire logic         polling_end,
	input wire logic [14:0]  channel_level,
	input wire logic [14:0]  pre_sleep_level,
	// Latched flags
	output logic [14:0]      level_change_flag
);

	typedef struct packed {
		logic [14:0] latch;
	} wlsr_latch_s;

	wlsr_latch_s st_ff;
	wlsr_latch_s nxt_st;

	// ==========================================================================
	// Capture
	// The wake mask is deliberately not an input: every channel is compared.
	always_comb begin
		nxt_st = st_ff;
		if (polling_end) begin
			nxt_st.latch = channel_level ^ pre_sleep_level; // RULE1 RULE2
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_ff.latch <= wlsr_pkg::LATCH_RST; // RULE3
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level_change_flag = st_ff.latch;

endmodule : wlsr_change_latch

// ### hw/wlsr_regs.sv
// Register block: polling change latch and four routed sensor outputs.
// Assumes a decoded register port from the serial frame logic on clk_sys;
// parity is added by that logic, so bit 15 reads as zero here.
`timescale 1ns/1ps

// Behaviour
// [RULE1] Polling end latches per-channel level differences.
// [RULE2] Flag set regardless of wake-source setting.
// [RULE3] Latch is read-only, cleared by power-on.
// [RULE4] Filter select bits 13:12, 1 is fast.
// [RULE5] Filter resets to its channel enable.
// [RULE6] Bypass bits 11:10 skip digital processing.
// [RULE7] Pull-up bits 9:8 connect 20k resistor.
// [RULE8] Selector 0 is high impedance, else channel.
// [RULE9] Output 1 route 3:0, output 2 7:4.
// [RULE10] Second register repeats layout for outputs 3,4.
// [RULE11] Enables per channel, reset to zero.
// [RULE12] Host avoids duplicate routes, routes before enabling.
module wlsr_regs (
	// Clock and resets
	input wire logic         clk_sys,
	input wire logic         reset_n,
	input wire logic         logic_reset_n,
	// Register port
	input wire logic [7:0]   reg_addr,
	input wire logic         reg_wr_en,
	input wire logic [15:0]  reg_wdata,
	input wire logic         reg_rd_en,
	output logic [15:0]      reg_rdata,
	// Polling and channel status
	input wire logic         polling_end,
	input wire logic [14:0]  channel_level,
	input wire logic [14:0]  pre_sleep_level,
	input wire logic [3:0]   sent_channel_enable,
	// Latch and routed outputs
	output logic [14:0]      level_change_flag,
	output logic [3:0]       sent_route_level,
	output logic [3:0]       sent_route_drive,
	output logic [3:0]       input_filter_speed,
	output logic [3:0]       digital_path_bypass,
	output logic [3:0]       passive_pullup_select
);

	typedef struct packed {
		logic [1:0]                                       lrst_sync;
		logic [15:0]                                      rdata;
		wlsr_pkg::wlsr_out_cfg_s [wlsr_pkg::NUM_OUTPUTS-1:0] cfg;
	} wlsr_regs_s;

	wlsr_regs_s st_ff;
	wlsr_regs_s nxt_st;
	logic       cfg_reset;

	// ==========================================================================
	// Reset value of one output's configuration
	function automatic wlsr_pkg::wlsr_out_cfg_s cfg_reset_value(input int idx, input logic enable);
		wlsr_pkg::wlsr_out_cfg_s v;
		v.filter_fast = enable; // RULE5 RULE11
		v.bypass      = wlsr_pkg::BYPASS_RST; // RULE6
		v.pull_en     = wlsr_pkg::PULLUP_RST; // RULE7
		v.route       = (idx == wlsr_pkg::NUM_OUTPUTS - 1) ? wlsr_pkg::ROUTE_RST_OUT4 : wlsr_pkg::ROUTE_RST_OTHER;
		return v;
	endfunction : cfg_reset_value

	// Packs two outputs' configuration into one register word.
	function automatic logic [15:0] pack_pair(input wlsr_pkg::wlsr_out_cfg_s lo, input wlsr_pkg::wlsr_out_cfg_s hi);
		logic [15:0] w;
		w = '0;
		w[wlsr_pkg::POS_ROUTE_LO +: wlsr_pkg::ROUTE_W] = lo.route; // RULE9 RULE10
		w[wlsr_pkg::POS_ROUTE_HI +: wlsr_pkg::ROUTE_W] = hi.route;
		w[wlsr_pkg::POS_PULLUP_LO] = lo.pull_en;
		w[wlsr_pkg::POS_PULLUP_HI] = hi.pull_en;
		w[wlsr_pkg::POS_BYPASS_LO] = lo.bypass;
		w[wlsr_pkg::POS_BYPASS_HI] = hi.bypass;
		w[wlsr_pkg::POS_FILTER_LO] = lo.filter_fast;
		w[wlsr_pkg::POS_FILTER_HI] = hi.filter_fast;
		return w;
	endfunction : pack_pair

	function automatic wlsr_pkg::wlsr_out_cfg_s unpack_out(input logic [15:0] w, input logic hi);
		wlsr_pkg::wlsr_out_cfg_s v;
		v.route       = hi ? w[wlsr_pkg::POS_ROUTE_HI +: wlsr_pkg::ROUTE_W]
		                   : w[wlsr_pkg::POS_ROUTE_LO +: wlsr_pkg::ROUTE_W]; // RULE9 RULE10
		v.pull_en     = hi ? w[wlsr_pkg::POS_PULLUP_HI] : w[wlsr_pkg::POS_PULLUP_LO]; // RULE7
		v.bypass      = hi ? w[wlsr_pkg::POS_BYPASS_HI] : w[wlsr_pkg::POS_BYPASS_LO]; // RULE6
		v.filter_fast = hi ? w[wlsr_pkg::POS_FILTER_HI] : w[wlsr_pkg::POS_FILTER_LO]; // RULE4
		return v;
	endfunction : unpack_out

	// ==========================================================================
	// Next state
	// The logic reset comes from a pin, so it is synchronised before use; it
	// clears the routing registers but never the power-on-only latch.
	assign cfg_reset = !st_ff.lrst_sync[1];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.lrst_sync = {st_ff.lrst_sync[0], logic_reset_n};
		if (cfg_reset) begin
			for (int i = 0; i < wlsr_pkg::NUM_OUTPUTS; i++) begin
				nxt_st.cfg[i] = cfg_reset_value(i, sent_channel_enable[i]); // RULE5
			end
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				wlsr_pkg::ADDR_ROUTE_1_2: begin
					nxt_st.cfg[0] = unpack_out(reg_wdata, 1'b0); // RULE9
					nxt_st.cfg[1] = unpack_out(reg_wdata, 1'b1);
				end
				wlsr_pkg::ADDR_ROUTE_3_4: begin
					nxt_st.cfg[2] = unpack_out(reg_wdata, 1'b0); // RULE10
					nxt_st.cfg[3] = unpack_out(reg_wdata, 1'b1);
				end
				default: begin
					// The latch address and unmapped addresses ignore writes.
					nxt_st.cfg = st_ff.cfg; // RULE3
				end
			endcase
		end
		if (reg_rd_en) begin
			unique case (reg_addr)
				wlsr_pkg::ADDR_CHANGE_LATCH: nxt_st.rdata = {1'b0, level_change_flag};
				wlsr_pkg::ADDR_ROUTE_1_2:    nxt_st.rdata = pack_pair(st_ff.cfg[0], st_ff.cfg[1]);
				wlsr_pkg::ADDR_ROUTE_3_4:    nxt_st.rdata = pack_pair(st_ff.cfg[2], st_ff.cfg[3]);
				default:                     nxt_st.rdata = wlsr_pkg::RDATA_RST;
			endcase
		end
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_ff.lrst_sync <= wlsr_pkg::SYNC_RST;
			st_ff.rdata     <= wlsr_pkg::RDATA_RST;
			for (int i = 0; i < wlsr_pkg::NUM_OUTPUTS; i++) begin
				st_ff.cfg[i] <= cfg_reset_value(i, sent_channel_enable[i]); // RULE5 RULE11
			end
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;

	// ==========================================================================
	// Change latch
	wlsr_change_latch u_latch (
		.clk_sys           (clk_sys),
		.reset_n           (reset_n),
		.polling_end       (polling_end),
		.channel_level     (channel_level),
		.pre_sleep_level   (pre_sleep_level),
		.level_change_flag (level_change_flag)
	);

	// ==========================================================================
	// Routing slots
	genvar g;
	generate
		for (g = 0; g < wlsr_pkg::NUM_OUTPUTS; g++) begin : g_slot
			wlsr_slot_if slot_bus ();

			assign slot_bus.route  = st_ff.cfg[g].route;
			assign slot_bus.levels = channel_level;

			wlsr_route_slot u_slot (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.port    (slot_bus.slot)
			);

			assign sent_route_level[g]      = slot_bus.level;
			assign sent_route_drive[g]      = slot_bus.drive; // RULE8
			assign input_filter_speed[g]    = st_ff.cfg[g].filter_fast; // RULE4
			assign digital_path_bypass[g]   = st_ff.cfg[g].bypass; // RULE6
			assign passive_pullup_select[g] = st_ff.cfg[g].pull_en; // RULE7
		end
	endgenerate

endmodule : wlsr_regs

// ### sim/wlsr_monitor.sv
// Port assertions for the wake-latch and routing register block.
// Assumes logic_reset_n is held high around the writes that are checked.
`timescale 1ns/1ps
module wlsr_monitor (
	// Clock and resets
	input logic        clk_sys,
	input logic        reset_n,
	input logic        logic_reset_n,
	// Register port
	input logic [7:0]  reg_addr,
	input logic        reg_wr_en,
	input logic [15:0] reg_wdata,
	input logic        reg_rd_en,
	input logic [15:0] reg_rdata,
	// Status and outputs
	input logic        polling_end,
	input logic [14:0] channel_level,
	input logic [14:0] pre_sleep_level,
	input logic [3:0]  sent_channel_enable,
	input logic [14:0] level_change_flag,
	input logic [3:0]  sent_route_level,
	input logic [3:0]  sent_route_drive,
	input logic [3:0]  input_filter_speed,
	input logic [3:0]  digital_path_bypass,
	input logic [3:0]  passive_pullup_select
);
	// ====================
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// A write only counts once the synchronised logic reset has been gone for a while.
	sequence wr_ok(a);
		logic_reset_n [*3] ##0 reg_wr_en && reg_addr == a;
	endsequence
	AST_LATCH_SET: assert property (polling_end |=> level_change_flag == $past(channel_level ^ pre_sleep_level))
		else $error("change latch wrong after polling end");
	AST_LATCH_HOLD: assert property (!polling_end |=> $stable(level_change_flag))
		else $error("change latch moved without polling end");
	AST_RST_VAL: assert property ($rose(reset_n) |-> level_change_flag == 15'h0000 && digital_path_bypass == 4'h0
		&& passive_pullup_select == 4'h0 && input_filter_speed == $past(sent_channel_enable))
		else $error("reset values wrong");
	AST_CFG12: assert property (wr_ok(wlsr_pkg::ADDR_ROUTE_1_2) |=>
		{input_filter_speed[1:0], digital_path_bypass[1:0], passive_pullup_select[1:0]} == $past(reg_wdata[13:8]))
		else $error("outputs 1 and 2 config wrong");
	AST_CFG34: assert property (wr_ok(wlsr_pkg::ADDR_ROUTE_3_4) |=>
		{input_filter_speed[3:2], digital_path_bypass[3:2], passive_pullup_select[3:2]} == $past(reg_wdata[13:8]))
		else $error("outputs 3 and 4 config wrong");
	AST_ROUTE_DRV: assert property (wr_ok(wlsr_pkg::ADDR_ROUTE_1_2) ##1 !reg_wr_en |=>
		sent_route_drive[0] == ($past(reg_wdata[3:0], 2) != 4'h0)) else $error("output 1 drive wrong");
	AST_UNDRIVEN: assert property ((sent_route_level & ~sent_route_drive) == 4'h0)
		else $error("undriven output shows a level");
	AST_RD_LATCH: assert property (reg_rd_en && reg_addr == wlsr_pkg::ADDR_CHANGE_LATCH |=>
		reg_rdata == {1'b0, $past(level_change_flag)}) else $error("latch read wrong");
	AST_LRST: assert property (!logic_reset_n [*4] |-> digital_path_bypass == 4'h0 && passive_pullup_select == 4'h0)
		else $error("logic reset did not clear config");
endmodule : wlsr_monitor

bind wlsr_regs wlsr_monitor wlsr_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n), .logic_reset_n(logic_reset_n),
	.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
	.polling_end(polling_end), .channel_level(channel_level), .pre_sleep_level(pre_sleep_level),
	.sent_channel_enable(sent_channel_enable), .level_change_flag(level_change_flag),
	.sent_route_level(sent_route_level), .sent_route_drive(sent_route_drive), .input_filter_speed(input_filter_speed),
	.digital_path_bypass(digital_path_bypass), .passive_pullup_select(passive_pullup_select));

// ### sim/wlsr_timer_model.sv
// Timer-side receiver of the four routed sensor lines.
// Assumes it runs on clk_sys beside the register block.
`timescale 1ns/1ps
module wlsr_timer_model (
	// Clock
	input wire logic        clk_sys,
	// Lines from the block
	input wire logic [3:0]  level,
	input wire logic [3:0]  drive,
	input wire logic [3:0]  pull_en,
	// Resolved line levels
	output logic [3:0]      line
);
	// ====================
	// Line resolution
	logic [3:0] last_ff;
	// A floating line without pull-up shows the inverse of its last level so a stale value never looks valid.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			line[i] = drive[i] ? level[i] : (pull_en[i] | ~last_ff[i]);
		end
	end
	always_ff @(posedge clk_sys) begin
		last_ff <= line;
	end
endmodule : wlsr_timer_model

// ### sim/tb_wlsr_regs.sv
// Self-checking bench for the register block.
// Assumes package, carrier, design, checker and timer model are compiled first.
`timescale 1ns/1ps
module tb_wlsr_regs;
	typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} wlsr_row_s;
	logic        clk_sys = 1'b0, reset_n = 1'b0, lrst_n = 1'b1, wr_en = 1'b0, rd_en = 1'b0, pend = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, r;
	logic [14:0] ch = 15'h5555, pre = 15'h0000, flag;
	logic [3:0]  en = 4'ha, lvl, drv, fil, byp, pu, line;
	int          err_count = 0, n_checks = 0, i, c;
	// Routes are set before any reception; the first row doubles output 4's reset route 15 on output 1.
	wlsr_row_s rows[6] = '{'{8'h34, 16'hffef, 16'h3fef}, '{8'h34, 16'h0021, 16'h0021}, '{8'h35, 16'h1a3c, 16'h1a3c},
		'{8'h35, 16'h0200, 16'h0200}, '{8'h33, 16'hffff, 16'h0000}, '{8'h40, 16'h1234, 16'h0000}};
	always #10 clk_sys = ~clk_sys;
	wlsr_regs wlsr_regs_inst (.clk_sys(clk_sys), .reset_n(reset_n), .logic_reset_n(lrst_n), .reg_addr(addr),
		.reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata(rdata), .polling_end(pend),
		.channel_level(ch), .pre_sleep_level(pre), .sent_channel_enable(en), .level_change_flag(flag),
		.sent_route_level(lvl), .sent_route_drive(drv), .input_filter_speed(fil), .digital_path_bypass(byp),
		.passive_pullup_select(pu));
	wlsr_timer_model wlsr_timer_model_inst (.clk_sys(clk_sys), .level(lvl), .drive(drv), .pull_en(pu), .line(line));
	// ====================
	// Tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk_sys);
		wr_en = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk_sys);
		rd_en = 1'b0;
		d = rdata;
	endtask : rd
	function automatic logic sel(input logic [3:0] s);
		return (s == 4'h0) ? 1'b0 : ch[s - 4'h1];
	endfunction : sel
	task finish_test;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	// ====================
	// Sequence
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_count++;
		finish_test;
	end
	initial begin
		repeat (4) @(negedge clk_sys);
		reset_n = 1'b1;
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			rd(rows[k].a, r);
			chk(r, rows[k].e);
			if (rows[k].a[7:1] == 7'h1a) begin
				i = rows[k].a[0] * 2;
				chk({fil[i+:2], byp[i+:2], pu[i+:2]}, rows[k].e[13:8]);
				chk(drv[i+:2], {rows[k].e[7:4] != 4'h0, rows[k].e[3:0] != 4'h0});
				chk(lvl[i+:2], {sel(rows[k].e[7:4]), sel(rows[k].e[3:0])});
			end
		end
		chk(line[3], 1'b1);
		for (c = 0; c < 16; c++) begin
			wr(8'h34, 16'(c));
			rd(8'h34, r);
			chk(drv[0], c != 0);
			chk(lvl[0], sel(4'(c)));
		end
		for (c = 0; c < 2; c++) begin
			pre = c ? 15'h0001 : ch;
			pend = 1'b1;
			@(negedge clk_sys);
			pend = 1'b0;
			rd(8'h33, r);
			chk(r, c ? 16'h5554 : 16'h0000);
		end
		lrst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		wr(8'h34, 16'h3fff);
		rd(8'h34, r);
		chk(r, 16'h2000);
		@(negedge clk_sys);
		rd(8'h33, r);
		chk(r, 16'h5554);
		lrst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		pre = 15'h0010;
		pend = 1'b1;
		@(negedge clk_sys);
		pend = 1'b0;
		reset_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		reset_n = 1'b1;
		rd(8'h35, r);
		chk(r, 16'h20f0);
		@(negedge clk_sys);
		rd(8'h33, r);
		chk(r, 16'h0000);
		chk(drv, 4'h8);
		finish_test;
	end
endmodule : tb_wlsr_regs
